// >>> hw/cpd_pkg.sv
package cpd_pkg;

  // ****************************************************
  // instruction form
  // ****************************************************
  // opcode bit that marks the 4-byte form
  localparam int LEN_BIT = 7;
  // strips form bit and byte bit from an opcode
  localparam logic [7:0] FORM_MASK = 8'h7e;
  // strips form bit and the two compare variant bits
  localparam logic [7:0] CMP_MASK = 8'h7c;

  // ****************************************************
  // opcodes (upper byte of the first word)
  // ****************************************************
  localparam logic [7:0] OP_ADDC = 8'h10;
  localparam logic [7:0] OP_SUBC = 8'h20;
  localparam logic [7:0] OP_MUL = 8'h30;
  localparam logic [7:0] OP_MULU = 8'h31;
  localparam logic [7:0] OP_DIV = 8'h32;
  localparam logic [7:0] OP_DIVU = 8'h33;
  localparam logic [7:0] OP_DIVL = 8'h34;
  localparam logic [7:0] OP_DIVLU = 8'h35;
  localparam logic [7:0] OP_NORM = 8'h40;
  localparam logic [7:0] OP_SIGN_SHIFT_RIGHT_OP = 8'h41;
  localparam logic [7:0] OP_MOVB = 8'h42;
  localparam logic [7:0] OP_CMP = 8'h50;
  localparam logic [7:0] OP_TRAP = 8'h60;
  localparam logic [7:0] OP_BMOV = 8'he0;
  localparam logic [7:0] OP_BMOVN = 8'he1;
  localparam logic [7:0] OP_BFLDL = 8'he2;
  localparam logic [7:0] OP_BFLDH = 8'he3;
  localparam logic [7:0] OP_JB = 8'he4;
  localparam logic [7:0] OP_JBC = 8'he5;
  localparam logic [7:0] OP_JNB = 8'he6;
  localparam logic [7:0] OP_JNBS = 8'he7;
  localparam logic [7:0] OP_PUSH_AND_CALL_OP = 8'he8;
  localparam logic [7:0] OP_CONTEXT_SWITCH_OP = 8'he9;
  localparam logic [7:0] OP_POWER_DOWN_ENTRY_OP = 8'hea;
  localparam logic [7:0] OP_IDLE = 8'heb;
  localparam logic [7:0] OP_SLEEP = 8'hec;
  localparam logic [7:0] OP_END_OF_INIT_OP = 8'hed;

  // ****************************************************
  // reset values, addresses and counts
  // ****************************************************
  localparam logic [15:0] IP_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'hfc00;
  localparam logic [15:0] BIT_BASE = 16'hfd00;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [5:0] DIV_STEPS = 6'h20;

endpackage

// >>> hw/cpd_gpr_mem.sv
`timescale 1ns/1ps
module cpd_gpr_mem (
  // clock
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // read ports
  input wire logic [3:0] ra_addr,
  input wire logic [3:0] rb_addr,
  output logic [15:0] ra_data,
  output logic [15:0] rb_data,
  // write port
  input wire logic we,
  input wire logic [3:0] wa,
  input wire logic [15:0] wd
);

  // ****************************************************
  // storage
  // ****************************************************
  // sixteen word registers, no reset on the array itself
  logic [15:0] mem [16];

  // write port, read during write returns the old word
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[wa] <= wd;
    end
  end

  // registered read data so it is clean at execute
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ra_data <= 16'h0000;
      rb_data <= 16'h0000;
    end else if (ce) begin
      ra_data <= mem[ra_addr];
      rb_data <= mem[rb_addr];
    end
  end

endmodule

// >>> hw/cpd_divider.sv
`timescale 1ns/1ps
module cpd_divider (
  // clock
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // request
  input wire logic start,
  input wire logic sgn,
  input wire logic [31:0] dividend,
  input wire logic [15:0] divisor,
  // answer
  output logic done,
  output logic [15:0] quo,
  output logic [15:0] rem
);

  // ****************************************************
  // magnitudes and one restoring step
  // ****************************************************
  // signed forms work on magnitudes and fix signs at the end
  wire neg_dd = sgn && dividend[31];
  wire neg_dv = sgn && divisor[15];
  wire [31:0] abs_dd = neg_dd ? 32'h0 - dividend : dividend;
  wire [15:0] abs_dv = neg_dv ? 16'h0 - divisor : divisor;
  logic [31:0] rq; // dividend shifting out, quotient in
  logic [15:0] r; // partial remainder
  logic [15:0] dv; // divisor magnitude
  logic [5:0] cnt; // steps left
  logic run; // step sequence active
  logic neg_q; // quotient to be negated
  logic neg_r; // remainder to be negated
  wire [16:0] rem_sh = {r, rq[31]};
  wire fits = rem_sh >= {1'h0, dv};
  wire [16:0] rem_sub = rem_sh - {1'h0, dv};

  // one bit per cycle; a zero divisor yields all ones, or 0001 for a negative signed dividend
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rq <= 32'h0;
      r <= 16'h0;
      dv <= 16'h0;
      cnt <= 6'h0;
      run <= 1'h0;
      neg_q <= 1'h0;
      neg_r <= 1'h0;
      done <= 1'h0;
      quo <= 16'h0;
      rem <= 16'h0;
    end else if (ce) begin
      done <= 1'h0;
      if (start) begin
        rq <= abs_dd;
        r <= 16'h0;
        dv <= abs_dv;
        cnt <= cpd_pkg::DIV_STEPS;
        run <= 1'h1;
        neg_q <= neg_dd ^ neg_dv;
        neg_r <= neg_dd;
      end else if (run && cnt != 6'h0) begin
        rq <= {rq[30:0], fits};
        r <= fits ? rem_sub[15:0] : rem_sh[15:0];
        cnt <= cnt - 6'h1;
      end else if (run) begin
        // quotient keeps only its low word
        run <= 1'h0;
        done <= 1'h1;
        quo <= neg_q ? 16'h0 - rq[15:0] : rq[15:0];
        rem <= neg_r ? 16'h0 - r : r;
      end
    end
  end

endmodule

// >>> hw/cpd_core.sv
`timescale 1ns/1ps
module cpd_core (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // fetch stage
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_word0,
  input wire logic [15:0] fetch_word1,
  output logic fetch_ready,
  output logic fetch_len4,
  output logic [15:0] ip,
  // data memory, stack and bit space
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  // status
  output logic flag_c,
  output logic flag_z,
  output logic flag_n,
  output logic flag_v,
  output logic [31:0] wide_product_reg,
  // mode control
  input wire logic nmi_n,
  input wire logic ext_irq,
  input wire logic irq_req,
  input wire logic rtc_keep,
  output logic cpu_run,
  output logic periph_clk_en,
  output logic rtc_clk_en,
  output logic reset_output_pin_n
);

  // ****************************************************
  // helper functions
  // ****************************************************
  // add or subtract with carry in; returns {v, c, result}
  function automatic logic [17:0] cpd_arith(
    input logic [15:0] a,
    input logic [15:0] b,
    input logic cin,
    input logic sub,
    input logic byt
  );
    logic [16:0] w;
    logic [8:0] y;
    logic [15:0] res;
    logic c;
    logic v;
    begin
      w = sub ? {1'h0, a} - {1'h0, b} - {16'h0, cin}
              : {1'h0, a} + {1'h0, b} + {16'h0, cin};
      y = sub ? {1'h0, a[7:0]} - {1'h0, b[7:0]} - {8'h0, cin}
              : {1'h0, a[7:0]} + {1'h0, b[7:0]} + {8'h0, cin};
      if (byt) begin
        // byte form leaves the upper byte alone
        res = {a[15:8], y[7:0]};
        c = y[8];
        v = ((a[7] ^ b[7]) ^ ~sub) & (a[7] ^ y[7]);
      end else begin
        res = w[15:0];
        c = w[16];
        v = ((a[15] ^ b[15]) ^ ~sub) & (a[15] ^ w[15]);
      end
      cpd_arith = {v, c, res};
    end
  endfunction

  // shifts needed until bit 15 is one; zero word gives 0
  function automatic logic [15:0] cpd_norm(input logic [15:0] x);
    logic [4:0] n;
    logic hit;
    begin
      n = 5'h00;
      hit = 1'h0;
      for (int i = 15; i >= 0; i--) begin
        if (!hit && x[i]) begin
          hit = 1'h1;
        end else if (!hit) begin
          n = n + 5'h01;
        end
      end
      if (!hit) begin
        n = 5'h00;
      end
      cpd_norm = {11'h000, n};
    end
  endfunction

  // word with one bit forced to a value
  function automatic logic [15:0] cpd_put(
    input logic [15:0] w,
    input logic [3:0] i,
    input logic b
  );
    logic [15:0] m;
    begin
      m = 16'h0001 << i;
      cpd_put = b ? (w | m) : (w & ~m);
    end
  endfunction

  // byte address of a bit-addressable word
  function automatic logic [15:0] cpd_baddr(input logic [7:0] a);
    cpd_baddr = cpd_pkg::BIT_BASE + {7'h00, a, 1'h0};
  endfunction

  // ****************************************************
  // state and held instruction
  // ****************************************************
  typedef enum logic [2:0] {
    S_FETCH, S_EXEC, S_DIV, S_MEM, S_POST, S_IDLE, S_SLEEP, S_PDOWN
  } cpd_state_t;
  cpd_state_t state;
  cpd_state_t next_state;
  logic [15:0] w0; // first opcode word
  logic [15:0] w1; // second word of a 4-byte form
  logic [15:0] sp; // stack pointer, grows down
  logic [15:0] maddr; // memory address held for the access
  logic [15:0] mwdata; // memory write data held
  logic [15:0] mdata; // word returned by the last read
  logic phase; // second pass of a two-access op
  logic bitv; // bit carried between the two bit accesses

  // ****************************************************
  // decode
  // ****************************************************
  wire [7:0] op = w0[15:8];
  wire [3:0] ra = w0[7:4];
  wire [3:0] rb = w0[3:0];
  wire is4 = op[cpd_pkg::LEN_BIT];
  wire [7:0] op_form = op & cpd_pkg::FORM_MASK;
  wire op_sum = op_form == cpd_pkg::OP_ADDC;
  wire op_diff = op_form == cpd_pkg::OP_SUBC;
  wire op_mul = op == cpd_pkg::OP_MUL || op == cpd_pkg::OP_MULU;
  wire op_div = (op & 8'hfc) == cpd_pkg::OP_DIV[7:0] - 8'h02 ?
                op != cpd_pkg::OP_MUL && op != cpd_pkg::OP_MULU
                : op == cpd_pkg::OP_DIVL || op == cpd_pkg::OP_DIVLU;
  wire op_long = op == cpd_pkg::OP_DIVL || op == cpd_pkg::OP_DIVLU;
  wire op_norm = op == cpd_pkg::OP_NORM;
  wire op_sign_shift_right_op = op == cpd_pkg::OP_SIGN_SHIFT_RIGHT_OP;
  wire op_movb = op_form == cpd_pkg::OP_MOVB;
  wire op_cmp = (op & cpd_pkg::CMP_MASK) == cpd_pkg::OP_CMP;
  wire op_trap = op == cpd_pkg::OP_TRAP;
  wire op_bmov = op == cpd_pkg::OP_BMOV || op == cpd_pkg::OP_BMOVN;
  wire op_bfld = op == cpd_pkg::OP_BFLDL || op == cpd_pkg::OP_BFLDH;
  wire op_jb = (op & 8'hfc) == cpd_pkg::OP_JB;
  wire op_push_and_call_op = op == cpd_pkg::OP_PUSH_AND_CALL_OP;
  wire op_context_switch_op = op == cpd_pkg::OP_CONTEXT_SWITCH_OP;
  wire op_push = op_trap || op_push_and_call_op || op_context_switch_op;
  wire op_bitmem = op_bmov || op_bfld || op_jb;
  // power down needs the nmi pin held low outside
  wire pdown_ok = op == cpd_pkg::OP_POWER_DOWN_ENTRY_OP && !nmi_n;

  // ****************************************************
  // register file
  // ****************************************************
  wire [15:0] va; // register named by ra
  wire [15:0] vb; // register named by rb
  wire in_fetch = state == S_FETCH;
  // addresses come straight from the fetch word so data is ready
  wire [3:0] rd_a = in_fetch ? fetch_word0[7:4] : ra;
  wire [3:0] rd_b = in_fetch ? fetch_word0[3:0] : rb;
  wire gpr_we;
  wire [15:0] gpr_wd;

  cpd_gpr_mem u_gpr (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .ra_addr(rd_a),
    .rb_addr(rd_b),
    .ra_data(va),
    .rb_data(vb),
    .we(gpr_we),
    .wa(ra),
    .wd(gpr_wd)
  );

  // ****************************************************
  // datapath
  // ****************************************************
  wire [15:0] opb = is4 ? w1 : vb; // immediate or register
  wire [17:0] sum_res = cpd_arith(va, opb, flag_c, op_diff, op[0]);
  wire [17:0] cmp_res = cpd_arith(va, opb, 1'h0, 1'h1, 1'h0);
  wire [15:0] step = op[0] ? 16'h0002 : 16'h0001;
  wire [15:0] cmp_next = op[1] ? va + step : va - step;
  wire [17:0] fres = op_cmp ? cmp_res : sum_res;
  wire fbyte = !op_cmp && op[0];
  wire fz = fbyte ? fres[7:0] == 8'h00 : fres[15:0] == 16'h0000;
  wire fn = fbyte ? fres[7] : fres[15];
  wire [31:0] product_op = {16'h0, va} * {16'h0, vb};
  wire signed [31:0] mul_s = $signed({{16{va[15]}}, va})
                           * $signed({{16{vb[15]}}, vb});
  wire [31:0] mul_res = op[0] ? product_op : mul_s;
  wire [15:0] norm = cpd_norm(vb);
  wire [15:0] sign_shift_right_op = $signed(va) >>> vb[3:0];
  wire [7:0] bsrc = is4 ? w1[7:0] : vb[7:0];
  wire [15:0] movb = op[0] ? {8'h00, bsrc}
                           : {{8{bsrc[7]}}, bsrc};
  // only these write a general register; context_switch_op loads the operand
  assign gpr_we = state == S_EXEC && (op_sum || op_diff || op_cmp
                  || op_norm || op_sign_shift_right_op || op_movb || op_context_switch_op);
  assign gpr_wd = op_cmp ? cmp_next
                : op_norm ? norm
                : op_sign_shift_right_op ? sign_shift_right_op
                : op_movb ? movb
                : op_context_switch_op ? w1
                : sum_res[15:0];

  // ****************************************************
  // divider
  // ****************************************************
  // short form widens the low half by the chosen sign rule
  wire div_sgn = !op[0];
  wire [31:0] div_dd = op_long ? wide_product_reg
    : div_sgn ? {{16{wide_product_reg[15]}}, wide_product_reg[15:0]}
    : {16'h0, wide_product_reg[15:0]};
  wire div_done;
  wire [15:0] div_quo;
  wire [15:0] div_rem;

  cpd_divider u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .start(state == S_EXEC && op_div),
    .sgn(div_sgn),
    .dividend(div_dd),
    .divisor(vb),
    .done(div_done),
    .quo(div_quo),
    .rem(div_rem)
  );

  // ****************************************************
  // bit space results
  // ****************************************************
  wire bit_src = mdata[w1[7:4]] ^ (op == cpd_pkg::OP_BMOVN);
  wire jb_bit = mdata[w1[15:12]];
  wire jb_one = op == cpd_pkg::OP_JB || op == cpd_pkg::OP_JBC;
  wire jb_take = jb_one ? jb_bit : !jb_bit;
  wire jb_mod = op == cpd_pkg::OP_JBC || op == cpd_pkg::OP_JNBS;
  wire [15:0] jb_wd = cpd_put(mdata, w1[15:12], !jb_bit);
  wire [15:0] jb_tgt = ip + {{7{w1[7]}}, w1[7:0], 1'h0};
  wire hi = op == cpd_pkg::OP_BFLDH;
  wire [15:0] bf_m = hi ? {w1[15:8], 8'h00} : {8'h00, w1[15:8]};
  wire [15:0] bf_d = hi ? {w1[7:0], 8'h00} : {8'h00, w1[7:0]};
  wire [15:0] bf_wd = (mdata & ~bf_m) | (bf_d & bf_m);
  wire post_go = op_bmov || op_bfld || (op_jb && jb_take && jb_mod);
  wire push_and_call_op_more = op_push_and_call_op && !phase;
  wire [15:0] push_at = sp - cpd_pkg::WORD_STEP;

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      S_FETCH: if (fetch_valid) next_state = S_EXEC;
      S_EXEC: begin
        if (op_div) next_state = S_DIV;
        else if (op_push || op_bitmem) next_state = S_MEM;
        else if (pdown_ok) next_state = S_PDOWN;
        else if (op == cpd_pkg::OP_IDLE) next_state = S_IDLE;
        else if (op == cpd_pkg::OP_SLEEP) next_state = S_SLEEP;
        else next_state = S_FETCH;
      end
      S_DIV: if (div_done) next_state = S_FETCH;
      S_MEM: begin
        if (mem_ack && !mem_we) next_state = S_POST;
        else if (mem_ack && !push_and_call_op_more) next_state = S_FETCH;
      end
      S_POST: next_state = post_go ? S_MEM : S_FETCH;
      // idle wakes on any interrupt request
      S_IDLE: if (irq_req || ext_irq) next_state = S_FETCH;
      S_SLEEP: if (ext_irq) next_state = S_FETCH;
      // power down is left only through reset
      S_PDOWN: next_state = S_PDOWN;
    endcase
  end

  // ****************************************************
  // state, pointer and stack
  // ****************************************************
  // length comes from the first word alone
  assign fetch_len4 = fetch_word0[8 + cpd_pkg::LEN_BIT];
  wire [15:0] ip_step = fetch_len4 ? 16'h0004 : 16'h0002;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= S_FETCH;
      ip <= cpd_pkg::IP_RST;
      w0 <= 16'h0000;
      w1 <= 16'h0000;
    end else if (ce) begin
      state <= next_state;
      if (in_fetch && fetch_valid) begin
        w0 <= fetch_word0;
        w1 <= fetch_word1;
        ip <= ip + ip_step;
      end else if (state == S_EXEC && op_trap) begin
        ip <= {7'h00, w0[6:0], 2'h0};
      end else if (state == S_MEM && mem_ack && op_push_and_call_op && phase) begin
        ip <= w1;
      end else if (state == S_POST && op_jb && jb_take) begin
        ip <= jb_tgt;
      end
    end
  end

  // ****************************************************
  // memory access control
  // ****************************************************
  // push_and_call_op pushes the register, then the return address
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sp <= cpd_pkg::SP_RST;
      maddr <= 16'h0000;
      mwdata <= 16'h0000;
      mem_we <= 1'h0;
      mdata <= 16'h0000;
      phase <= 1'h0;
      bitv <= 1'h0;
    end else if (ce) begin
      if (state == S_EXEC && op_push) begin
        sp <= push_at;
        maddr <= push_at;
        mwdata <= op_trap ? ip : va;
        mem_we <= 1'h1;
        phase <= 1'h0;
      end else if (state == S_EXEC && op_bitmem) begin
        maddr <= cpd_baddr(w0[7:0]);
        mem_we <= 1'h0;
        phase <= 1'h0;
      end else if (state == S_MEM && mem_ack) begin
        mdata <= mem_rdata;
        if (mem_we && push_and_call_op_more) begin
          sp <= push_at;
          maddr <= push_at;
          mwdata <= ip;
          phase <= 1'h1;
        end
      end else if (state == S_POST && op_bmov && !phase) begin
        // second read fetches the destination word
        bitv <= bit_src;
        maddr <= cpd_baddr(w1[15:8]);
        phase <= 1'h1;
      end else if (state == S_POST && post_go) begin
        mem_we <= 1'h1;
        mwdata <= op_bmov ? cpd_put(mdata, w1[3:0], bitv)
                : op_bfld ? bf_wd
                : jb_wd;
      end
    end
  end

  // ****************************************************
  // flags and product register
  // ****************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_c <= 1'h0;
      flag_z <= 1'h0;
      flag_n <= 1'h0;
      flag_v <= 1'h0;
      wide_product_reg <= 32'h0;
    end else if (ce) begin
      if (state == S_EXEC && (op_sum || op_diff || op_cmp)) begin
        flag_c <= fres[16];
        flag_v <= fres[17];
        flag_z <= fz;
        flag_n <= fn;
      end
      if (state == S_EXEC && op_mul) begin
        wide_product_reg <= mul_res;
      end else if (state == S_DIV && div_done) begin
        // remainder high, quotient low
        wide_product_reg <= {div_rem, div_quo};
      end
    end
  end

  // ****************************************************
  // reset output and mode outputs
  // ****************************************************
  // held low from reset until initialisation is declared done
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reset_output_pin_n <= 1'h0;
    end else if (ce && state == S_EXEC && op == cpd_pkg::OP_END_OF_INIT_OP) begin
      reset_output_pin_n <= 1'h1;
    end
  end

  wire deep = state == S_SLEEP || state == S_PDOWN;
  assign cpu_run = !(state == S_IDLE || deep);
  assign periph_clk_en = !deep;
  // the real-time clock may be kept alive through deep modes
  assign rtc_clk_en = !deep || rtc_keep;
  assign fetch_ready = in_fetch;
  assign mem_req = state == S_MEM;
  assign mem_addr = maddr;
  assign mem_wdata = mwdata;

endmodule

// >>> tb/cpd_core_asserts.sv
`timescale 1ns/1ps
// ****************************
// port checker for the core
// ****************************
module cpd_core_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // fetch side
  input wire logic ce,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_word0,
  input wire logic fetch_ready,
  input wire logic fetch_len4,
  input wire logic [15:0] ip,
  // memory side
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic [15:0] mem_addr,
  // mode control
  input wire logic nmi_n,
  input wire logic ext_irq,
  input wire logic rtc_keep,
  input wire logic cpu_run,
  input wire logic periph_clk_en,
  input wire logic rtc_clk_en,
  input wire logic reset_output_pin_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire take = ce && fetch_ready && fetch_valid; // instruction accepted
  wire [7:0] opc = fetch_word0[15:8]; // opcode byte
  sequence s_pwr_nop;
    take && opc == cpd_pkg::OP_POWER_DOWN_ENTRY_OP && nmi_n;
  endsequence
  sequence s_sleep;
    take && opc == cpd_pkg::OP_SLEEP;
  endsequence
  sequence s_idle;
    take && opc == cpd_pkg::OP_IDLE;
  endsequence
  property p_len;
    fetch_len4 == fetch_word0[8 + cpd_pkg::LEN_BIT];
  endproperty
  property p_ip;
    take |=> ip == $past(ip) + ($past(fetch_len4) ? 16'h4 : 16'h2);
  endproperty
  property p_rst_out;
    reset_output_pin_n |=> reset_output_pin_n;
  endproperty
  property p_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
  endproperty
  property p_pwr_nop;
    s_pwr_nop |=> periph_clk_en [*4];
  endproperty
  property p_sleep;
    s_sleep |-> ##[1:4] !periph_clk_en;
  endproperty
  property p_wake;
    !periph_clk_en && !ext_irq |=> !periph_clk_en;
  endproperty
  property p_rtc;
    !periph_clk_en |-> rtc_clk_en == rtc_keep;
  endproperty
  property p_idle;
    s_idle |-> ##[1:4] (!cpu_run && periph_clk_en);
  endproperty
  a_len: assert property (p_len) else $error("length flag wrong");
  a_ip: assert property (p_ip) else $error("pointer step wrong");
  a_rst_out: assert property (p_rst_out) else $error("reset out fell");
  a_hold: assert property (p_hold) else $error("access dropped");
  a_pwr_nop: assert property (p_pwr_nop) else $error("stop, nmi high");
  a_sleep: assert property (p_sleep) else $error("sleep missing");
  a_wake: assert property (p_wake) else $error("woke w/o irq");
  a_rtc: assert property (p_rtc) else $error("rtc clock wrong");
  a_idle: assert property (p_idle) else $error("idle wrong");
endmodule
bind cpd_core cpd_core_asserts i_chk (.clk(clk), .sys_rst(sys_rst),
  .ce(ce), .fetch_valid(fetch_valid), .fetch_word0(fetch_word0),
  .fetch_ready(fetch_ready), .fetch_len4(fetch_len4), .ip(ip),
  .mem_req(mem_req), .mem_ack(mem_ack), .mem_addr(mem_addr),
  .nmi_n(nmi_n), .ext_irq(ext_irq), .rtc_keep(rtc_keep),
  .cpu_run(cpu_run), .periph_clk_en(periph_clk_en),
  .rtc_clk_en(rtc_clk_en), .reset_output_pin_n(reset_output_pin_n));

// >>> tb/cpd_mem_model.sv
`timescale 1ns/1ps
// ****************************
// data memory and stack model
// ****************************
module cpd_mem_model (
  // clock
  input wire logic clk,
  // access from core
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  // wait states before each answer
  input wire logic [1:0] slow
);
  logic [15:0] mem [0:32767]; // word store
  logic [15:0] last_wa = 16'h0; // last write, seen by bench
  logic [15:0] last_wd = 16'h0;
  logic [15:0] junk = 16'h5a5a; // toggles, so stale data never passes
  logic [1:0] cnt = 2'h0; // wait state count
  initial mem_ack = 1'b0;
  assign mem_rdata = mem_ack ? mem[mem_addr[15:1]] : junk;
  // answer after slow extra cycles, write on the answering edge
  always @(posedge clk) begin
    junk <= ~junk;
    if (mem_req && mem_ack && mem_we) begin
      mem[mem_addr[15:1]] <= mem_wdata;
      last_wa <= mem_addr;
      last_wd <= mem_wdata;
    end
    if (mem_req && !mem_ack && cnt >= slow) begin
      mem_ack <= 1'b1;
      cnt <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack) cnt <= cnt + 2'h1;
    end
  end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ****************************
  // signals and instances
  // ****************************
  logic clk = 0, sys_rst = 1, ce = 1, fetch_valid = 0, mem_ack;
  logic nmi_n = 1, ext_irq = 0, irq_req = 0, rtc_keep = 0;
  logic [15:0] w0 = 16'h0, w1 = 16'h0, mem_rdata, ip, mem_addr, mem_wdata;
  logic fetch_ready, fetch_len4, mem_req, mem_we, fz, fn, fv, flag_c;
  logic cpu_run, periph_clk_en, rtc_clk_en, rst_o;
  logic [31:0] wpr;
  logic [1:0] slow = 2'h0;
  int err_count = 0, checks_done = 0;
  cpd_core i_cpd_core (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .fetch_valid(fetch_valid), .fetch_word0(w0), .fetch_word1(w1),
    .fetch_ready(fetch_ready), .fetch_len4(fetch_len4), .ip(ip),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .flag_c(flag_c), .flag_z(fz), .flag_n(fn), .flag_v(fv),
    .wide_product_reg(wpr), .nmi_n(nmi_n), .ext_irq(ext_irq),
    .irq_req(irq_req), .rtc_keep(rtc_keep), .cpu_run(cpu_run),
    .periph_clk_en(periph_clk_en), .rtc_clk_en(rtc_clk_en),
    .reset_output_pin_n(rst_o));
  cpd_mem_model i_cpd_mem_model (.clk(clk), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .slow(slow));
  initial forever #4 clk = ~clk;
  initial begin
    #400000;
    err_count++;
    give_verdict;
  end
  task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task give_verdict;
    $display("mismatches %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // offer one instruction, hold it to the taking edge, maybe await end
  task automatic go(logic [15:0] a, logic [15:0] b, bit wt);
    int n;
    n = 0;
    while (fetch_ready !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1 n++;
    end
    w0 = a;
    w1 = b;
    fetch_valid = 1;
    slow = $urandom % 4;
    @(posedge clk);
    #1 fetch_valid = 0;
    while (wt && fetch_ready !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 300) err_count++;
  endtask
  // ****************************
  // scenarios
  // ****************************
  logic [15:0] a, b, d, m, p;
  logic [31:0] pr;
  int c = 0, full, s, k;
  bit sb, byt;
  initial begin
    s = $urandom(36);
    repeat (4) @(posedge clk);
    #1 sys_rst = 0;
    chk("rst_out", rst_o, 0);
    go(16'he910, 16'h0, 1);
    chk("push_addr", i_cpd_mem_model.last_wa, 16'hfbfe);
    for (int i = 0; i < 8; i++) begin
      a = $urandom;
      b = $urandom;
      sb = i[0];
      byt = i[1];
      m = byt ? 16'hff : 16'hffff;
      go(16'he910, a, 1);
      go(16'he920, b, 1);
      go({(sb ? 8'h20 : 8'h10) | {7'h0, byt}, 8'h12}, 16'h0, 1);
      full = sb ? int'(a & m) - int'(b & m) - c : int'(a & m) + int'(b & m) + c;
      c = sb ? (full < 0) : (full > int'(m));
      chk("carry", flag_c, c);
      k = byt ? 7 : 15;
      chk("zero", fz, (full & m) == 0);
      chk("neg", fn, full[k]);
      chk("ovf", fv, (a[k] ^ b[k] ^ !sb) & (a[k] ^ full[k]));
      go(16'he910, 16'h0, 1);
      chk("sum", i_cpd_mem_model.last_wd & m, full & m);
    end
    a = $urandom;
    b = $urandom | 1;
    d = b | 16'h8000;
    pr = a * b;
    go(16'he910, a, 1);
    go(16'he920, b, 1);
    go(16'he930, d, 1);
    go(16'h3112, 16'h0, 1);
    chk("product", wpr, pr);
    go(16'h3533, 16'h0, 1);
    chk("long_quot", wpr, {16'(pr % d), 16'(pr / d)});
    i_cpd_mem_model.mem[16'hfd20 >> 1] = 16'h0008;
    p = ip;
    go(16'he510, 16'h3004, 1);
    chk("jb_ip", ip, p + 16'hc);
    chk("jb_clr", i_cpd_mem_model.mem[16'hfd20 >> 1], 16'h0);
    p = ip;
    go(16'he710, 16'h3002, 1);
    chk("jnb_ip", ip, p + 16'h8);
    chk("jnb_set", i_cpd_mem_model.mem[16'hfd20 >> 1], 16'h8);
    p = ip;
    go(16'h6005, 16'h0, 1);
    chk("trap_ip", ip, 16'h0014);
    chk("trap_ret", i_cpd_mem_model.last_wd, p + 16'h2);
    go(16'hea00, 16'h0, 1);
    repeat (4) @(posedge clk);
    #1 chk("pwr_nop", cpu_run, 1);
    rtc_keep = 1;
    go(16'hec00, 16'h0, 0);
    repeat (4) @(posedge clk);
    #1 chk("sleep", periph_clk_en, 0);
    chk("rtc_on", rtc_clk_en, 1);
    ext_irq = 1;
    repeat (4) @(posedge clk);
    #1 ext_irq = 0;
    chk("wake", periph_clk_en, 1);
    go(16'heb00, 16'h0, 0);
    repeat (4) @(posedge clk);
    #1 chk("idle_cpu", cpu_run, 0);
    chk("idle_per", periph_clk_en, 1);
    irq_req = 1;
    repeat (4) @(posedge clk);
    #1 irq_req = 0;
    chk("idle_end", cpu_run, 1);
    go(16'hed00, 16'h0, 1);
    chk("end_of_init_op", rst_o, 1);
    rtc_keep = 0;
    nmi_n = 0;
    go(16'hea00, 16'h0, 0);
    repeat (4) @(posedge clk);
    #1 chk("pwr_cpu", cpu_run, 0);
    chk("pwr_clk", {periph_clk_en, rtc_clk_en}, 0);
    give_verdict;
  end
endmodule
